// [hstc_cfg.svh]
`ifndef HSTC_CFG_SVH
`define HSTC_CFG_SVH
`define HSTC_OFS_GAIN 14'h20f0
`define HSTC_OFS_ELEC 14'h20f8
`define HSTC_OFS_AMP 14'h20fc
`define HSTC_RST_GAIN 13'h000f
`define HSTC_RST_ELEC 8'hff
`define HSTC_RST_AMP 2'h0
`define HSTC_RST_GSEL 4'hf
`define HSTC_GAIN_W 13
`define HSTC_ELEC_W 8
`define HSTC_AMP_W 2
`define HSTC_CAP_HI 12
`define HSTC_CAP_LO 5
`define HSTC_DIODE_BIT 4
`define HSTC_GSEL_HI 3
`define HSTC_OPEN_BIT 3
`define HSTC_CODE_100R_160K 8'h8c
`define HSTC_CODE_SHORT 8'h97
`define HSTC_RSV_INPUT 1
`define HSTC_ADDR_LO 2
`define HSTC_ADDR_HI 13
`define HSTC_TRANS_NONSEQ 2'h2
`define HSTC_TRANS_SEQ 2'h3
`endif

// [hstc_pkg.sv]
package hstc_pkg;
    typedef enum logic [1:0] {
        HSTC_POS_BIAS = 2'b00,
        HSTC_POS_DAC_ZERO = 2'b01,
        HSTC_POS_RSV2 = 2'b10,
        HSTC_POS_RSV3 = 2'b11
    } hstc_pos_e;
    typedef logic [31:0] hstc_word_t;
endpackage

// [hstc_ahb_if_slave.sv]
`timescale 1ns/100ps
`include "hstc_cfg.svh"
module hstc_ahb_if_slave
    import hstc_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    output logic wr_q,
    output logic rd_q,
    output logic [13:0] addr_q
);
    wire logic take;
    // address phase is latched; the data phase then completes with zero wait
    assign take = hsel && hready && (htrans == `HSTC_TRANS_NONSEQ || htrans == `HSTC_TRANS_SEQ);
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            wr_q <= 1'b0;
            rd_q <= 1'b0;
            addr_q <= 14'h0000;
        end
        else
        begin
            wr_q <= take && hwrite;
            rd_q <= take && !hwrite;
            if (take)
                addr_q <= haddr[13:0];
        end
    end
endmodule // hstc_ahb_if_slave

// [hstc_regs.sv]
`timescale 1ns/100ps
`include "hstc_cfg.svh"
// Functional notes
// (RULE1) gain config at 0x20f0, resets to 0xf, gain selection open
// (RULE2) bits 12:5 feedback capacitor field, rw, reset zero
// (RULE3) bit 4 diode switch, 1 closes, reset 0
// (RULE4) bits 3:0 gain select: 0-7 resistors, 8-15 open
// (RULE5) software sets routing switches before using general gain select
// (RULE6) electrode config at 0x20f8, bits 7:0 code, reset 0xff disconnected
// (RULE7) software sets routing switches, then writes electrode code
// (RULE8) electrode code 0x8c selects 100 ohm load with 160k gain
// (RULE9) amplifier input config at 0x20fc, rw, reset zero
// (RULE10) bits 1:0 positive input: 00 bias, 01 dac zero, rest reserved
// (RULE11) electrode code 0x97 shorts load and gain resistors
// (RULE12) reserved bits read zero, writes ignored
module hstc_regs
    import hstc_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    output logic [7:0] feedback_cap_select,
    output logic diode_switch,
    output logic [3:0] general_gain_select,
    output logic gain_open,
    output logic [7:0] electrode_resistor_code,
    output logic electrode_disconnected,
    output logic electrode_100r_160k,
    output logic electrode_short,
    output logic [1:0] positive_input_select,
    output logic positive_input_reserved
);
    logic [`HSTC_GAIN_W-1:0] gain_q;
    logic [`HSTC_ELEC_W-1:0] elec_q;
    logic [`HSTC_AMP_W-1:0] amp_q;
    logic wr_q;
    logic rd_q;
    logic [13:0] addr_q;
    wire logic hit_gain;
    wire logic hit_elec;
    wire logic hit_amp;
    wire hstc_word_t rdata_d;
    wire logic rd_take;
    wire logic rd_gain;
    wire logic rd_elec;
    wire logic rd_amp;
    wire logic [`HSTC_GAIN_W-1:0] gain_d;
    wire logic [`HSTC_ELEC_W-1:0] elec_d;
    wire logic [`HSTC_AMP_W-1:0] amp_d;

    function automatic logic is_reg(input logic [13:0] a, input logic [13:0] ofs);
        is_reg = (a[`HSTC_ADDR_HI:`HSTC_ADDR_LO] == ofs[`HSTC_ADDR_HI:`HSTC_ADDR_LO]);
    endfunction

    function automatic logic is_xfer(input logic [1:0] t);
        is_xfer = (t == `HSTC_TRANS_NONSEQ) || (t == `HSTC_TRANS_SEQ);
    endfunction

    hstc_ahb_if_slave hstc_ahb_if_slave_inst
    (
        .clock(clock),
        .rst(rst),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hready(hready),
        .wr_q(wr_q),
        .rd_q(rd_q),
        .addr_q(addr_q)
    );

    assign hit_gain = is_reg(addr_q, `HSTC_OFS_GAIN); // RULE1
    assign hit_elec = is_reg(addr_q, `HSTC_OFS_ELEC); // RULE6
    assign hit_amp = is_reg(addr_q, `HSTC_OFS_AMP); // RULE9

    // read decode runs in the address phase so hrdata stands in the data phase
    assign rd_take = hsel && hready && is_xfer(htrans) && !hwrite;
    assign rd_gain = is_reg(haddr[`HSTC_ADDR_HI:0], `HSTC_OFS_GAIN); // RULE1
    assign rd_elec = is_reg(haddr[`HSTC_ADDR_HI:0], `HSTC_OFS_ELEC); // RULE6
    assign rd_amp = is_reg(haddr[`HSTC_ADDR_HI:0], `HSTC_OFS_AMP); // RULE9

    // next values; a write ending now is forwarded to a read starting now
    assign gain_d = (wr_q && hit_gain) ? hwdata[`HSTC_GAIN_W-1:0] : gain_q; // RULE2 RULE3 RULE4
    assign elec_d = (wr_q && hit_elec) ? hwdata[`HSTC_ELEC_W-1:0] : elec_q; // RULE6
    assign amp_d = (wr_q && hit_amp) ? hwdata[`HSTC_AMP_W-1:0] : amp_q; // RULE10

    // unmapped reads return zero; reserved bits zero-filled
    assign rdata_d = rd_gain ? {19'h00000, gain_d} :
        rd_elec ? {24'h000000, elec_d} :
        rd_amp ? {30'h0, amp_d} : 32'h00000000; // RULE12

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            gain_q <= `HSTC_RST_GAIN; // RULE1 RULE2 RULE3 RULE4
            elec_q <= `HSTC_RST_ELEC; // RULE6
            amp_q <= `HSTC_RST_AMP; // RULE9
            hrdata <= 32'h00000000;
        end
        else
        begin
            // only implemented bits are stored, so reserved writes vanish
            gain_q <= gain_d; // RULE2 RULE3 RULE4 RULE12
            elec_q <= elec_d; // RULE6 RULE12
            amp_q <= amp_d; // RULE9 RULE10 RULE12
            hrdata <= rd_take ? rdata_d : 32'h00000000; // RULE12
        end
    end

    // outputs registered a second time so they come straight from flops
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            feedback_cap_select <= 8'h00;
            diode_switch <= 1'b0;
            general_gain_select <= `HSTC_RST_GSEL;
            gain_open <= 1'b1;
            electrode_resistor_code <= `HSTC_RST_ELEC;
            electrode_disconnected <= 1'b1;
            electrode_100r_160k <= 1'b0;
            electrode_short <= 1'b0;
            positive_input_select <= 2'h0;
            positive_input_reserved <= 1'b0;
        end
        else
        begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            feedback_cap_select <= gain_q[`HSTC_CAP_HI:`HSTC_CAP_LO]; // RULE2
            diode_switch <= gain_q[`HSTC_DIODE_BIT]; // RULE3
            general_gain_select <= gain_q[`HSTC_GSEL_HI:0]; // RULE4
            gain_open <= gain_q[`HSTC_OPEN_BIT]; // RULE4
            electrode_resistor_code <= elec_q; // RULE6
            electrode_disconnected <= (elec_q == `HSTC_RST_ELEC); // RULE6
            electrode_100r_160k <= (elec_q == `HSTC_CODE_100R_160K); // RULE8
            electrode_short <= (elec_q == `HSTC_CODE_SHORT); // RULE11
            positive_input_select <= amp_q; // RULE10
            positive_input_reserved <= amp_q[`HSTC_RSV_INPUT]; // RULE10
        end
    end

    a_gain_write: assert property (@(posedge clock) disable iff (rst) // RULE4
        wr_q && hit_gain |=> ##1 general_gain_select == $past(hwdata[3:0], 2))
        else $error("gain select not updated");
    a_gain_open: assert property (@(posedge clock) disable iff (rst) // RULE4
        gain_open == general_gain_select[3])
        else $error("gain open mismatch");
    a_cap_field: assert property (@(posedge clock) disable iff (rst) // RULE2
        wr_q && hit_gain |=> ##1 feedback_cap_select == $past(hwdata[12:5], 2))
        else $error("cap field not updated");
    a_diode_sw: assert property (@(posedge clock) disable iff (rst) // RULE3
        wr_q && hit_gain |=> ##1 diode_switch == $past(hwdata[4], 2))
        else $error("diode switch not updated");
    a_elec_code: assert property (@(posedge clock) disable iff (rst) // RULE6
        wr_q && hit_elec |=> ##1 electrode_resistor_code == $past(hwdata[7:0], 2))
        else $error("electrode code not updated");
    a_elec_8c: assert property (@(posedge clock) disable iff (rst) // RULE8
        electrode_100r_160k == (electrode_resistor_code == `HSTC_CODE_100R_160K))
        else $error("100r/160k decode wrong");
    a_elec_short: assert property (@(posedge clock) disable iff (rst) // RULE11
        electrode_short == (electrode_resistor_code == `HSTC_CODE_SHORT))
        else $error("short decode wrong");
    a_elec_disc: assert property (@(posedge clock) disable iff (rst) // RULE6
        electrode_disconnected == (electrode_resistor_code == `HSTC_RST_ELEC))
        else $error("disconnect decode wrong");
    a_amp_sel: assert property (@(posedge clock) disable iff (rst) // RULE9
        wr_q && hit_amp |=> ##1 positive_input_select == $past(hwdata[1:0], 2))
        else $error("input select not updated");
    a_amp_rsv: assert property (@(posedge clock) disable iff (rst) // RULE10
        positive_input_reserved == positive_input_select[`HSTC_RSV_INPUT])
        else $error("reserved input flag wrong");

    a_rsv_read: assert property (@(posedge clock) disable iff (rst) // RULE12
        rd_q && hit_elec |-> hrdata[31:8] == 24'h000000)
        else $error("reserved bits nonzero");
    a_read_gain: assert property (@(posedge clock) disable iff (rst) // RULE1
        rd_q && hit_gain |-> hrdata == {19'h00000, gain_q})
        else $error("gain read data wrong");
    a_read_elec: assert property (@(posedge clock) disable iff (rst) // RULE6
        rd_q && hit_elec |-> hrdata == {24'h000000, elec_q})
        else $error("electrode read data wrong");
    a_read_amp: assert property (@(posedge clock) disable iff (rst) // RULE9
        rd_q && hit_amp |-> hrdata == {30'h0, amp_q})
        else $error("amp read data wrong");
    a_read_hole: assert property (@(posedge clock) disable iff (rst) // RULE12
        rd_q && !hit_gain && !hit_elec && !hit_amp |-> hrdata == 32'h00000000)
        else $error("unmapped read nonzero");
    a_write_hole: assert property (@(posedge clock) disable iff (rst) // RULE12
        wr_q && !hit_gain |=> gain_q == $past(gain_q))
        else $error("gain changed by other write");

    a_gain_reset: assert property (@(posedge clock) // RULE1
        $past(rst) && !rst |-> general_gain_select == `HSTC_RST_GSEL && gain_open)
        else $error("gain reset wrong");
    a_cap_reset: assert property (@(posedge clock) // RULE2
        $past(rst) && !rst |-> feedback_cap_select == 8'h00 && !diode_switch)
        else $error("cap reset wrong");
    a_elec_reset: assert property (@(posedge clock) // RULE6
        $past(rst) && !rst |-> electrode_disconnected && electrode_resistor_code == `HSTC_RST_ELEC)
        else $error("electrode reset wrong");
    a_amp_reset: assert property (@(posedge clock) // RULE9
        $past(rst) && !rst |-> positive_input_select == `HSTC_RST_AMP && !positive_input_reserved)
        else $error("amp reset wrong");

    c_gain_wr: cover property (@(posedge clock) wr_q && hit_gain);
    c_elec_short: cover property (@(posedge clock) electrode_short);
    c_amp_rd: cover property (@(posedge clock) rd_q && hit_amp);
    c_elec_8c: cover property (@(posedge clock) electrode_100r_160k);
    c_rst_release: cover property (@(posedge clock) $past(rst) && !rst);
endmodule // hstc_regs

// [hstc_regs_tb.sv]
`timescale 1ns/100ps
module hstc_regs_tb
    import hstc_pkg::*;
;
    logic clock, rst, hsel, hwrite, hready, hreadyout, hresp, diode_switch, gain_open;
    logic electrode_disconnected, electrode_100r_160k, electrode_short, positive_input_reserved;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans, positive_input_select;
    logic [2:0] hsize;
    logic [7:0] feedback_cap_select, electrode_resistor_code;
    logic [3:0] general_gain_select;
    hstc_word_t rd;
    int num_errors = 0;
    int total_checks = 0;
    assign hready = hreadyout;
    hstc_regs hstc_regs_inst (.clock(clock), .rst(rst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready), .hwdata(hwdata),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .feedback_cap_select(feedback_cap_select), .diode_switch(diode_switch),
        .general_gain_select(general_gain_select), .gain_open(gain_open),
        .electrode_resistor_code(electrode_resistor_code),
        .electrode_disconnected(electrode_disconnected),
        .electrode_100r_160k(electrode_100r_160k), .electrode_short(electrode_short),
        .positive_input_select(positive_input_select),
        .positive_input_reserved(positive_input_reserved));
    initial
    begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end
    task test_done;
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task chk(input hstc_word_t got, input hstc_word_t exp, input string what);
        total_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    // address phase held until ready, data phase held until ready again
    task xfer(input logic wr, input hstc_word_t a, input hstc_word_t d);
        haddr <= a;
        hwrite <= wr;
        htrans <= 2'h2;
        do @(posedge clock); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clock); while (hready !== 1'b1);
        rd = hrdata;
        chk({31'h0, hresp}, 32'h0, "resp");
    endtask
    task rdchk(input hstc_word_t a, input hstc_word_t exp);
        xfer(1'b0, a, 32'h0);
        chk(rd, exp, "read");
    endtask
    initial
    begin
        #200000;
        num_errors++;
        $display("MISMATCH %0t watchdog expired", $time);
        test_done();
    end
    initial
    begin
        rst <= 1'b1;
        hsel <= 1'b1;
        haddr <= '0;
        htrans <= 2'h0;
        hwrite <= 1'b0;
        hsize <= 3'h2;
        hwdata <= '0;
        repeat (3) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        rdchk(32'h20f0, 32'hf);
        rdchk(32'h20f8, 32'hff);
        rdchk(32'h20fc, 32'h0);
        chk({31'h0, gain_open & electrode_disconnected}, 32'h1, "reset flags");
        $display("test reset done");
        xfer(1'b1, 32'h20f0, 32'hffffffff);
        rdchk(32'h20f0, 32'h1fff);
        chk({23'h0, feedback_cap_select, diode_switch}, 32'h1ff, "cap diode");
        xfer(1'b1, 32'h20f0, 32'h00000aa0);
        rdchk(32'h20f0, 32'haa0);
        chk({23'h0, feedback_cap_select, diode_switch}, 32'haa, "cap order");
        for (int i = 0; i < 16; i++)
        begin
            xfer(1'b1, 32'h20f0, {27'h0, i[0], i[3:0]});
            rdchk(32'h20f0, {27'h0, i[0], i[3:0]});
            chk({27'h0, gain_open, general_gain_select}, {27'h0, i[3], i[3:0]}, "gsel");
            chk({31'h0, diode_switch}, {31'h0, i[0]}, "diode");
        end
        $display("test gain done");
        xfer(1'b1, 32'h20f8, 32'hffffff8c);
        rdchk(32'h20f8, 32'h8c);
        chk({29'h0, electrode_100r_160k, electrode_short, electrode_disconnected}, 32'h4,
            "code 8c");
        xfer(1'b1, 32'h20f8, 32'h97);
        // decode flags follow two edges after the write lands
        repeat (2) @(posedge clock);
        chk({29'h0, electrode_100r_160k, electrode_short, electrode_disconnected}, 32'h2,
            "code 97");
        // unmapped hole between registers: write dropped, reads zero
        xfer(1'b1, 32'h20f4, 32'hffffffff);
        rdchk(32'h20f4, 32'h0);
        rdchk(32'h20f8, 32'h97);
        chk({24'h0, electrode_resistor_code}, 32'h97, "code");
        $display("test electrode done");
        for (int i = 0; i < 4; i++)
        begin
            xfer(1'b1, 32'h20fc, {30'h3fffffff, i[1:0]});
            rdchk(32'h20fc, {30'h0, i[1:0]});
            chk({29'h0, positive_input_reserved, positive_input_select}, {29'h0, i[1], i[1:0]},
                "posin");
        end
        $display("test amp done");
        // mid-run reset must bring every register back to its reset value
        rst <= 1'b1;
        repeat (3) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        rdchk(32'h20f0, 32'hf);
        rdchk(32'h20f8, 32'hff);
        rdchk(32'h20fc, 32'h0);
        chk({30'h0, gain_open, electrode_disconnected}, 32'h3, "rerst flags");
        $display("test reset again done");
        test_done();
    end
endmodule // hstc_regs_tb
